//--- hdl/can_buf_pkg.sv
/*
 * Holds the message buffer word layout: word indices, field positions and
 * widths, implemented-bit masks, buffer count and FIFO sizing.
 * Assumes one 16-bit wide buffer memory, eight words per buffer.
 */
package can_buf_pkg;

    // ----------
    // Sizes
    // ----------
    localparam int WORD_W      = 16;
    localparam int WORDS_PER   = 8;
    localparam int WIDX_W      = 3;
    localparam int NUM_BUFS    = 4;
    localparam int BIDX_W      = 2;
    localparam int ADDR_W      = BIDX_W + WIDX_W;
    localparam int FIFO_DEPTH  = 8;
    localparam int FIFO_W      = ADDR_W + WORD_W;

    // ----------
    // Word indices
    // ----------
    localparam logic [2:0] W_STD_IDENT   = 3'h0;
    localparam logic [2:0] W_EXT_HIGH    = 3'h1;
    localparam logic [2:0] W_EXT_LOW_LEN = 3'h2;
    localparam logic [2:0] W_PAYLOAD_0   = 3'h3;
    localparam logic [2:0] W_FILTER_HIT  = 3'h7;

    // ----------
    // Field positions and widths
    // ----------
    localparam int STD_LSB     = 2;
    localparam int STD_W       = 11;
    localparam int SRR_BIT     = 1;
    localparam int EXT_SEL_BIT = 0;
    localparam int EXT_W       = 18;
    localparam int EXT_HI_LSB  = 0;
    localparam int EXT_HI_W    = 12;
    localparam int EXT_LO_LSB  = 10;
    localparam int EXT_LO_W    = 6;
    localparam int RTR_BIT     = 9;
    localparam int RZH_BIT     = 8;
    localparam int RZL_BIT     = 4;
    localparam int LEN_LSB     = 0;
    localparam int LEN_W       = 4;
    localparam int BYTE_LO_LSB = 0;
    localparam int BYTE_HI_LSB = 8;
    localparam int HIT_LSB     = 8;
    localparam int HIT_W       = 5;

    // ----------
    // Implemented bits per word; the rest store and read as zero
    // ----------
    localparam logic [15:0] MASK_STD_IDENT   = 16'h1FFF;
    localparam logic [15:0] MASK_EXT_HIGH    = 16'h0FFF;
    localparam logic [15:0] MASK_EXT_LOW_LEN = 16'hFF1F;
    localparam logic [15:0] MASK_PAYLOAD     = 16'hFFFF;
    localparam logic [15:0] MASK_FILTER_HIT  = 16'h1F00;

    function automatic logic [15:0] word_mask(input logic [2:0] idx);
        logic [15:0] m;
        m = MASK_PAYLOAD;
        case (idx)
            W_STD_IDENT:   m = MASK_STD_IDENT;
            W_EXT_HIGH:    m = MASK_EXT_HIGH;
            W_EXT_LOW_LEN: m = MASK_EXT_LOW_LEN;
            W_FILTER_HIT:  m = MASK_FILTER_HIT;
            default:       m = MASK_PAYLOAD;
        endcase
        return m;
    endfunction

    typedef enum logic [1:0] {
        PK_IDLE = 2'b00,
        PK_PUSH = 2'b01
    } pack_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_READ = 2'b01,
        TX_HOLD = 2'b11
    } tx_state_t;

endpackage

//--- hdl/word_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock; full and empty come from an occupancy count.
 */
`timescale 1ns/10ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;

    wire do_push = in_valid && in_ready;
    wire do_pop  = out_valid && out_ready;

    assign in_ready  = (count != (PTR_W+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];

    always_ff @(posedge mclk) begin
        if (do_push) begin
            store[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);
        end
    end

endmodule

//--- hdl/can_msg_buffer.sv
/*
 * Message buffer memory with its word layout: a host word port for software
 * and DMA, a transmit unpacker feeding the protocol engine, and a receive
 * packer that writes frames back through an eight-entry FIFO.
 * Assumes the protocol engine and the host share mclk and that buffer
 * direction bits come from the buffer control logic outside.
 */
`timescale 1ns/10ps

// Overview of operation
// - Word 0 holds the 11-bit standard identifier in bits 12..2 with bits 15..13 reading zero.
// - Word 0 bit 1 is the substitute remote request flag, one for a remote request.
// - Word 0 bit 0 selects extended identifier format when one, standard only when zero.
// - The 18-bit extended identifier has its top twelve bits in word 1 bits 11..0 and low six in word 2 bits 15..10.
// - Word 2 bit 9 is the remote transmission request flag, one for a remote frame.
// - Word 2 bits 3..0 hold the four-bit data length code.
// - Words 3..6 hold payload bytes 0..7 in order, lower byte of each pair in the low half.
// - On reception the controller writes the five-bit accepting filter number into word 7 bits 12..8.
// - The filter hit field is written only for receive buffers and left alone for transmit buffers.
// - Unimplemented positions, including word 2 bits 7..5 and word 7 bits 7..0, read as zero.
module can_msg_buffer
    import can_buf_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 host_sel,
    input  wire logic                 host_wr,
    input  wire logic [ADDR_W-1:0]    host_addr,
    input  wire logic [WORD_W-1:0]    host_wdata,
    output logic      [WORD_W-1:0]    host_rdata,

    input  wire logic [NUM_BUFS-1:0]  buffer_direction_select,

    input  wire logic                 tx_req,
    input  wire logic [BIDX_W-1:0]    tx_buf,
    input  wire logic                 tx_taken,
    output logic                      tx_busy,

    output logic                      tx_valid,
    output logic      [STD_W-1:0]     tx_std_ident,
    output logic                      tx_srr,
    output logic                      tx_ext_sel,
    output logic      [EXT_W-1:0]     tx_ext_ident,
    output logic                      tx_rtr,
    output logic                      tx_reserved_zero_high,
    output logic                      tx_reserved_zero_low,
    output logic      [LEN_W-1:0]     tx_len,
    output logic      [63:0]          tx_payload,

    input  wire logic                 rx_valid,
    output logic                      rx_ready,

    input  wire logic [BIDX_W-1:0]    rx_buf,
    input  wire logic [STD_W-1:0]     rx_std_ident,
    input  wire logic                 rx_srr,
    input  wire logic                 rx_ext_sel,
    input  wire logic [EXT_W-1:0]     rx_ext_ident,
    input  wire logic                 rx_rtr,
    input  wire logic                 rx_reserved_zero_high,
    input  wire logic                 rx_reserved_zero_low,
    input  wire logic [LEN_W-1:0]     rx_len,
    input  wire logic [63:0]          rx_payload,
    input  wire logic [HIT_W-1:0]     rx_filter_hit_code
);

    // ------------------------------------------------------------
    // Buffer memory, no reset: contents undefined until written
    // ------------------------------------------------------------
    logic [WORD_W-1:0] mem [NUM_BUFS*WORDS_PER];

    // ------------------------------------------------------------
    // Receive packer state
    // ------------------------------------------------------------
    pack_state_t       pk_state;
    logic [WIDX_W-1:0] pk_idx;
    logic [BIDX_W-1:0] pk_buf;
    logic [WORD_W-1:0] pk_words [WORDS_PER];
    logic              pk_is_tx;

    wire               fifo_in_ready;
    wire               fifo_out_valid;
    wire [FIFO_W-1:0]  fifo_out_data;

    // Word 7 of a transmit buffer is skipped, its filter field untouched
    wire skip_word  = pk_is_tx && (pk_idx == W_FILTER_HIT);
    wire pk_push    = (pk_state == PK_PUSH) && !skip_word;
    wire pk_advance = (pk_state == PK_PUSH) && (skip_word || fifo_in_ready);
    wire pk_last    = (pk_idx == WIDX_W'(WORDS_PER-1));
    wire rx_take    = rx_valid && rx_ready;

    wire [FIFO_W-1:0] pk_entry = {pk_buf, pk_idx, pk_words[pk_idx]};

    // Packed layout of an incoming frame
    wire [WORD_W-1:0] rx_w0 = (WORD_W'(rx_std_ident) << STD_LSB)
                            | (WORD_W'(rx_srr) << SRR_BIT)
                            | (WORD_W'(rx_ext_sel) << EXT_SEL_BIT);

    wire [WORD_W-1:0] rx_w1 = WORD_W'(rx_ext_ident[EXT_W-1 -: EXT_HI_W]) << EXT_HI_LSB;

    wire [WORD_W-1:0] rx_w2 = (WORD_W'(rx_ext_ident[EXT_LO_W-1:0]) << EXT_LO_LSB)
                            | (WORD_W'(rx_rtr) << RTR_BIT)
                            | (WORD_W'(rx_reserved_zero_high) << RZH_BIT)
                            | (WORD_W'(rx_reserved_zero_low) << RZL_BIT)
                            | (WORD_W'(rx_len) << LEN_LSB);

    wire [WORD_W-1:0] rx_w7 = WORD_W'(rx_filter_hit_code) << HIT_LSB;

    // Capture the whole frame at accept
    always_ff @(posedge mclk) begin
        if (rx_take) begin
            pk_words[0] <= rx_w0;
            pk_words[1] <= rx_w1;
            pk_words[2] <= rx_w2;
            for (int i = 0; i < 4; i++) begin
                pk_words[3+i] <= {rx_payload[16*i+BYTE_HI_LSB +: 8],
                                  rx_payload[16*i+BYTE_LO_LSB +: 8]};
            end
            pk_words[7] <= rx_w7;
        end
    end

    // Accept a frame, then push its words
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pk_state <= PK_IDLE;
            pk_idx   <= '0;
            pk_buf   <= '0;
            pk_is_tx <= 1'b0;
            rx_ready <= 1'b0;
        end else begin
            case (pk_state)
                PK_IDLE: begin
                    rx_ready <= 1'b1;
                    if (rx_take) begin
                        pk_state <= PK_PUSH;
                        pk_idx   <= '0;
                        pk_buf   <= rx_buf;
                        pk_is_tx <= buffer_direction_select[rx_buf];
                        rx_ready <= 1'b0;
                    end
                end

                PK_PUSH: begin
                    if (pk_advance) begin
                        pk_idx <= pk_idx + 1'b1;
                        if (pk_last) begin
                            pk_state <= PK_IDLE;
                            rx_ready <= 1'b1;
                        end
                    end
                end

                default: begin
                    pk_state <= PK_IDLE;
                    rx_ready <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Write FIFO between packer and memory
    // ------------------------------------------------------------
    wire host_write = host_sel && host_wr;
    wire fifo_drain = !host_write;

    word_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_write_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (pk_push),
        .in_ready  (fifo_in_ready),
        .in_data   (pk_entry),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_drain),
        .out_data  (fifo_out_data)
    );

    // ------------------------------------------------------------
    // Memory write port: host first, then the FIFO
    // ------------------------------------------------------------
    wire [ADDR_W-1:0] wr_addr  = host_write ? host_addr : fifo_out_data[FIFO_W-1 -: ADDR_W];
    wire [WORD_W-1:0] wr_raw   = host_write ? host_wdata : fifo_out_data[WORD_W-1:0];
    wire              wr_en    = host_write || fifo_out_valid;
    wire [WORD_W-1:0] wr_data  = wr_raw & word_mask(wr_addr[WIDX_W-1:0]);

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read, masked again
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            host_rdata <= '0;
        end else if (host_sel && !host_wr) begin
            host_rdata <= mem[host_addr] & word_mask(host_addr[WIDX_W-1:0]);
        end
    end

    // ------------------------------------------------------------
    // Transmit unpacker
    // ------------------------------------------------------------
    tx_state_t         tx_state;
    logic [WIDX_W-1:0] tx_idx;
    logic [BIDX_W-1:0] tx_sel;

    wire [WORD_W-1:0] tx_word = mem[{tx_sel, tx_idx}] & word_mask(tx_idx);
    wire              tx_read = (tx_state == TX_READ);
    wire              tx_last = (tx_idx == WIDX_W'(WORDS_PER-1));

    // Eight word reads, then hold until taken
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_idx   <= '0;
            tx_sel   <= '0;
            tx_valid <= 1'b0;
            tx_busy  <= 1'b0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (tx_req) begin
                        tx_state <= TX_READ;
                        tx_sel   <= tx_buf;
                        tx_idx   <= '0;
                        tx_busy  <= 1'b1;
                    end
                end

                TX_READ: begin
                    tx_idx <= tx_idx + 1'b1;
                    if (tx_last) begin
                        tx_state <= TX_HOLD;
                        tx_valid <= 1'b1;
                    end
                end

                TX_HOLD: begin
                    if (tx_taken) begin
                        tx_state <= TX_IDLE;
                        tx_valid <= 1'b0;
                        tx_busy  <= 1'b0;
                    end
                end

                default: begin
                    tx_state <= TX_IDLE;
                    tx_valid <= 1'b0;
                    tx_busy  <= 1'b0;
                end
            endcase
        end
    end

    // Each word read except word 7 lands in its fields; word 7 has no transmit field
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_std_ident          <= '0;
            tx_srr                <= 1'b0;
            tx_ext_sel            <= 1'b0;
            tx_ext_ident          <= '0;
            tx_rtr                <= 1'b0;
            tx_reserved_zero_high <= 1'b0;
            tx_reserved_zero_low  <= 1'b0;
            tx_len                <= '0;
            tx_payload            <= '0;
        end else if (tx_read) begin
            case (tx_idx)
                W_STD_IDENT: begin
                    tx_std_ident <= tx_word[STD_LSB +: STD_W];
                    tx_srr       <= tx_word[SRR_BIT];
                    tx_ext_sel   <= tx_word[EXT_SEL_BIT];
                end

                W_EXT_HIGH: begin
                    tx_ext_ident[EXT_W-1 -: EXT_HI_W] <= tx_word[EXT_HI_LSB +: EXT_HI_W];
                end

                W_EXT_LOW_LEN: begin
                    tx_ext_ident[EXT_LO_W-1:0] <= tx_word[EXT_LO_LSB +: EXT_LO_W];
                    tx_rtr                     <= tx_word[RTR_BIT];
                    tx_reserved_zero_high      <= tx_word[RZH_BIT];
                    tx_reserved_zero_low       <= tx_word[RZL_BIT];
                    tx_len                     <= tx_word[LEN_LSB +: LEN_W];
                end

                W_FILTER_HIT: begin
                    tx_payload <= tx_payload;
                end

                default: begin
                    tx_payload[16*(tx_idx-W_PAYLOAD_0) +: 16] <= tx_word;
                end
            endcase
        end
    end

endmodule

//--- bench/can_msg_buffer_asserts.sv
/*
 * Checker for read masks, read hold, transmit and receive timing.
 * Assumes it is bound to can_msg_buffer.
 */
`timescale 1ns/10ps
module can_msg_buffer_asserts
    import can_buf_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              host_sel,
    input wire logic              host_wr,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [WORD_W-1:0] host_rdata,
    input wire logic              tx_req,
    input wire logic              tx_taken,
    input wire logic              tx_busy,
    input wire logic              tx_valid,
    input wire logic [STD_W-1:0]  tx_std_ident,
    input wire logic [63:0]       tx_payload,
    input wire logic              rx_valid,
    input wire logic              rx_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    wire logic       host_read = host_sel && !host_wr;
    wire logic [2:0] word_idx  = host_addr[2:0];

    a_word0_top_zero: assert property (host_read && word_idx == 3'h0 |=> host_rdata[15:13] == 3'h0)
        else $error("word 0 top set");
    a_word1_top_zero: assert property (host_read && word_idx == 3'h1 |=> host_rdata[15:12] == 4'h0)
        else $error("word 1 top set");
    a_word2_gap_zero: assert property (host_read && word_idx == 3'h2 |=> host_rdata[7:5] == 3'h0)
        else $error("word 2 gap set");
    a_word7_only_hit: assert property (host_read && word_idx == 3'h7
        |=> host_rdata[15:13] == 3'h0 && host_rdata[7:0] == 8'h00)
        else $error("word 7 stray bits");
    a_rdata_holds: assert property (!host_read |=> $stable(host_rdata))
        else $error("read data moved");
    a_tx_eight_reads: assert property (tx_req && !tx_busy
        |=> (tx_busy && !tx_valid) [*8] ##1 (tx_valid && tx_busy))
        else $error("tx unpack length");
    a_tx_fields_hold: assert property (tx_valid && !tx_taken
        |=> tx_valid && $stable(tx_payload) && $stable(tx_std_ident))
        else $error("tx fields moved");
    a_tx_release: assert property (tx_valid && tx_taken |=> !tx_valid && !tx_busy)
        else $error("tx not released");
    a_rx_eight_words: assert property (rx_valid && rx_ready |=> !rx_ready [*8] ##[1:40] rx_ready)
        else $error("rx busy time");

    c_tx_taken: cover property (tx_valid && tx_taken);
    c_rx_accept: cover property (rx_valid && rx_ready);
    c_write_while_packing: cover property (host_sel && host_wr && !rx_ready);
endmodule

bind can_msg_buffer can_msg_buffer_asserts can_msg_buffer_asserts_i (
    .mclk(mclk), .rst(rst), .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr),
    .host_rdata(host_rdata), .tx_req(tx_req), .tx_taken(tx_taken), .tx_busy(tx_busy),
    .tx_valid(tx_valid), .tx_std_ident(tx_std_ident), .tx_payload(tx_payload),
    .rx_valid(rx_valid), .rx_ready(rx_ready));

//--- bench/can_engine_model.sv
/*
 * Engine model: requests and takes transmit frames, offers receive frames.
 * Assumes its tasks start just after a rising edge of mclk.
 */
`timescale 1ns/10ps
module can_engine_model
    import can_buf_pkg::*;
(
    input  wire logic              mclk,
    output logic                   tx_req,
    output logic      [BIDX_W-1:0] tx_buf,
    output logic                   tx_taken,
    output logic                   rx_valid,
    input  wire logic              rx_ready,
    output logic      [BIDX_W-1:0] rx_buf,
    output logic      [STD_W-1:0]  rx_std_ident,
    output logic                   rx_srr,
    output logic                   rx_ext_sel,
    output logic      [EXT_W-1:0]  rx_ext_ident,
    output logic                   rx_rtr,
    output logic                   rx_reserved_zero_high,
    output logic                   rx_reserved_zero_low,
    output logic      [LEN_W-1:0]  rx_len,
    output logic      [63:0]       rx_payload,
    output logic      [HIT_W-1:0]  rx_filter_hit_code
);
    initial begin
        {tx_req, tx_buf, tx_taken, rx_valid, rx_buf, rx_std_ident, rx_srr, rx_ext_sel} = '0;
        {rx_ext_ident, rx_rtr, rx_reserved_zero_high, rx_reserved_zero_low, rx_len} = '0;
        {rx_payload, rx_filter_hit_code} = '0;
    end

    task automatic request_tx(input logic [BIDX_W-1:0] b);
        tx_req = 1'b1;
        tx_buf = b;
        @(posedge mclk);
        #1;
        tx_req = 1'b0;
        tx_buf = ~b;
    endtask

    task automatic take_tx(input int stall);
        repeat (stall) begin
            @(posedge mclk);
            #1;
        end
        tx_taken = 1'b1;
        @(posedge mclk);
        #1;
        tx_taken = 1'b0;
    endtask

    task automatic push_rx(input int k, output logic ok);
        int n;
        {rx_buf, rx_std_ident, rx_srr, rx_ext_sel} = {2'(k), 11'h3C5 ^ 11'(k), k[0], 1'b1};
        {rx_ext_ident, rx_rtr, rx_len} = {18'h2A5A5 ^ 18'(k), k[0], 4'(k)};
        {rx_payload, rx_filter_hit_code} = {64'h0123456789ABCDEF + 64'(k), 5'h0A + 5'(k)};
        rx_reserved_zero_high = 1'b0;
        rx_reserved_zero_low = 1'b0;
        rx_valid = 1'b1;
        for (n = 0; rx_ready !== 1'b1 && n < 60; n++) begin
            @(posedge mclk);
            #1;
        end
        ok = rx_ready;
        @(posedge mclk);
        #1;
        rx_valid = 1'b0;
        // Released identifier and payload fields no longer show the frame
        {rx_std_ident, rx_ext_ident, rx_payload} = ~{rx_std_ident, rx_ext_ident, rx_payload};
    endtask
endmodule

//--- bench/can_msg_buffer_bench.sv
/*
 * Bench: host masks, transmit unpack, two received frames.
 * Assumes 25 MHz mclk and the engine model on the frame ports.
 */
`timescale 1ns/10ps
module can_msg_buffer_bench
    import can_buf_pkg::*;
;
    localparam time SKEW = 1;
    localparam logic [15:0] MASK_TAB [8] = '{16'h1FFF, 16'h0FFF, 16'hFF1F, 16'hFFFF,
                                             16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h1F00};
    localparam logic [15:0] TX_TAB [8] = '{16'hF68F, 16'hFABC, 16'hB6E8, 16'h2211,
                                           16'h4433, 16'h6655, 16'h8877, 16'h1234};
    logic mclk, rst, host_sel, host_wr, tx_req, tx_taken, tx_busy, tx_valid, rx_valid, rx_ready;
    logic tx_srr, tx_ext_sel, tx_rtr, tx_rzh, tx_rzl, rx_srr, rx_ext_sel, rx_rtr, rx_rzh, rx_rzl;
    logic [ADDR_W-1:0] host_addr;
    logic [WORD_W-1:0] host_wdata, host_rdata;
    logic [NUM_BUFS-1:0] buffer_direction_select;
    logic [BIDX_W-1:0] tx_buf, rx_buf;
    logic [STD_W-1:0] tx_std_ident, rx_std_ident;
    logic [EXT_W-1:0] tx_ext_ident, rx_ext_ident;
    logic [LEN_W-1:0] tx_len, rx_len;
    logic [63:0] tx_payload, rx_payload;
    logic [HIT_W-1:0] rx_filter_hit_code;
    logic ok2, ok3;
    int bad_count, samples_checked, n;

    can_msg_buffer can_msg_buffer_i (.mclk(mclk), .rst(rst), .host_sel(host_sel), .host_wr(host_wr),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .buffer_direction_select(buffer_direction_select), .tx_req(tx_req), .tx_buf(tx_buf),
        .tx_taken(tx_taken), .tx_busy(tx_busy), .tx_valid(tx_valid), .tx_std_ident(tx_std_ident),
        .tx_srr(tx_srr), .tx_ext_sel(tx_ext_sel), .tx_ext_ident(tx_ext_ident), .tx_rtr(tx_rtr),
        .tx_reserved_zero_high(tx_rzh), .tx_reserved_zero_low(tx_rzl), .tx_len(tx_len),
        .tx_payload(tx_payload), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_buf(rx_buf),
        .rx_std_ident(rx_std_ident), .rx_srr(rx_srr), .rx_ext_sel(rx_ext_sel), .rx_ext_ident(rx_ext_ident),
        .rx_rtr(rx_rtr), .rx_reserved_zero_high(rx_rzh), .rx_reserved_zero_low(rx_rzl), .rx_len(rx_len),
        .rx_payload(rx_payload), .rx_filter_hit_code(rx_filter_hit_code));

    can_engine_model can_engine_model_i (.mclk(mclk), .tx_req(tx_req), .tx_buf(tx_buf), .tx_taken(tx_taken),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_buf(rx_buf), .rx_std_ident(rx_std_ident),
        .rx_srr(rx_srr), .rx_ext_sel(rx_ext_sel), .rx_ext_ident(rx_ext_ident), .rx_rtr(rx_rtr),
        .rx_reserved_zero_high(rx_rzh), .rx_reserved_zero_low(rx_rzl), .rx_len(rx_len),
        .rx_payload(rx_payload), .rx_filter_hit_code(rx_filter_hit_code));

    always #20 mclk = ~mclk;

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic host_access(input logic wr, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        host_sel = 1'b1;
        host_wr = wr;
        host_addr = a;
        host_wdata = d;
        @(posedge mclk);
        #SKEW;
    endtask

    task automatic host_idle();
        host_sel = 1'b0;
        host_wr = 1'b0;
    endtask

    // Expected word w of frame k
    function automatic logic [15:0] frame_word(input int k, input int w, input logic dir);
        logic [EXT_W-1:0] e;
        logic [63:0] p;
        e = 18'h2A5A5 ^ 18'(k);
        p = 64'h0123456789ABCDEF + 64'(k);
        case (w)
            0: return {3'h0, 11'h3C5 ^ 11'(k), k[0], 1'b1};
            1: return {4'h0, e[17:6]};
            2: return {e[5:0], k[0], 1'b0, 3'h0, 1'b0, 4'(k)};
            7: return dir ? 16'h1F00 : {3'h0, 5'h0A + 5'(k), 8'h00};
            default: return p[16*(w-3) +: 16];
        endcase
    endfunction

    task automatic finish_test();
        $display("Checked %0d values, %0d mismatches", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge mclk);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        {mclk, host_sel, host_wr, host_addr, host_wdata} = '0;
        rst = 1'b1;
        buffer_direction_select = 4'hA;
        repeat (16) @(posedge mclk);
        check("reset", {tx_busy, tx_valid, rx_ready, host_rdata}, '0);
        #SKEW;
        rst = 1'b0;
        repeat (2) @(posedge mclk);
        #SKEW;
        check("ready", rx_ready, 1'b1);
        // ----------
        // Masks
        // ----------
        for (int w = 0; w < 8; w++) host_access(1'b1, {2'd0, 3'(w)}, 16'hFFFF);
        for (int w = 0; w < 8; w++) begin
            host_access(1'b0, {2'd0, 3'(w)}, 16'h0000);
            check("mask", host_rdata, MASK_TAB[w]);
        end
        host_idle();
        $display("test masks done");
        // ----------
        // Transmit, refused second request
        // ----------
        for (int w = 0; w < 8; w++) host_access(1'b1, {2'd1, 3'(w)}, TX_TAB[w]);
        host_idle();
        can_engine_model_i.request_tx(2'd1);
        @(posedge mclk);
        #SKEW;
        can_engine_model_i.request_tx(2'd0);
        for (n = 0; tx_valid !== 1'b1 && n < 40; n++) #40;
        check("tx std", tx_std_ident, 11'h5A3);
        check("tx flags", {tx_srr, tx_ext_sel, tx_rtr, tx_rzh, tx_rzl}, 5'b11100);
        check("tx ext", tx_ext_ident, {12'hABC, 6'h2D});
        check("tx len", tx_len, 4'h8);
        check("tx payload", tx_payload, 64'h8877665544332211);
        can_engine_model_i.take_tx(3);
        check("tx free", {tx_busy, tx_valid}, 2'b00);
        $display("test transmit done");
        // ----------
        // Receive two frames while host writes stall the drain
        // ----------
        host_access(1'b1, {2'd2, 3'd7}, 16'hFFFF);
        host_access(1'b1, {2'd3, 3'd7}, 16'hFFFF);
        fork
            begin
                can_engine_model_i.push_rx(2, ok2);
                @(posedge mclk);
                #SKEW;
                can_engine_model_i.push_rx(3, ok3);
            end
            for (int i = 0; i < 20; i++) host_access(1'b1, {2'd0, 3'd3}, 16'h1000 + 16'(i));
        join
        host_idle();
        check("accepted", {ok2, ok3}, 2'b11);
        repeat (12) @(posedge mclk);
        #SKEW;
        for (int k = 2; k < 4; k++) begin
            for (int w = 0; w < 8; w++) begin
                host_access(1'b0, {2'(k), 3'(w)}, 16'h0000);
                check("rx word", host_rdata, frame_word(k, w, k == 3));
            end
        end
        host_access(1'b0, {2'd0, 3'd3}, 16'h0000);
        check("host word", host_rdata, 16'h1013);
        host_idle();
        $display("test receive done");
        finish_test();
    end
endmodule
